// File: hw/sfc_link_cfg.svh
// constants for the serial flash command link: codes, status bits, timing
`ifndef SFC_LINK_CFG_SVH
`define SFC_LINK_CFG_SVH
// command codes
`define SFC_OP_WRITE_LATCH_SET 8'h06
`define SFC_OP_WRITE_LATCH_CLEAR 8'h04
`define SFC_OP_STANDARD_IDENT_READ 8'h9f
`define SFC_OP_SMALL_REGION_WIPE 8'h20
`define SFC_OP_LARGE_REGION_WIPE_A 8'h52
`define SFC_OP_LARGE_REGION_WIPE_B 8'hd8
`define SFC_OP_WHOLE_WIPE_A 8'h60
`define SFC_OP_WHOLE_WIPE_B 8'hc7
`define SFC_OP_DEEP_SLEEP_ENTRY 8'hb9
`define SFC_OP_WAKE_AND_SIGNATURE_READ 8'hab
`define SFC_OP_STATUS_REGISTER_WRITE 8'h01
`define SFC_OP_STATUS_READ 8'h05
`define SFC_OP_ARRAY_READ 8'h03
// status register fields and values
`define SFC_ST_BUSY_BIT 0
`define SFC_ST_WRITE_ALLOW_BIT 1
`define SFC_ST_WRITABLE_MASK 8'h8c
`define SFC_ST_LOCK_BIT 7
`define SFC_ST_RESET 8'h00
`define SFC_ERASED_BYTE 8'hff
// frame lengths in serial clocks
`define SFC_BITS_CMD 6'd8
`define SFC_BITS_STATUS_WRITE 6'd16
`define SFC_BITS_ADDR_CMD 6'd32
// timing: system clock and documented times in their own units
`define SFC_CLK_KHZ 40000
`define SFC_T_DESELECT_NS 100
`define SFC_T_SLEEP_ENTRY_US 3
`define SFC_T_WAKE_US 3
`define SFC_T_WAKE_SIG_NS 1800
`define SFC_T_STATUS_WRITE_TYP_MS 5
`define SFC_T_STATUS_WRITE_MAX_MS 15
`define SFC_T_SMALL_WIPE_TYP_MS 60
`define SFC_T_LARGE_WIPE_TYP_MS 1000
`define SFC_T_LARGE_WIPE_MAX_MS 2000
`define SFC_T_WHOLE_WIPE_TYP_MS 1800
`define SFC_T_WHOLE_WIPE_MAX_MS 3800
`define SFC_READ_MAX_KHZ 33000
`define SFC_MIN_KHZ 1
// derived cycle counts: deselect time rounds up, wake time rounds down, ms times are exact
`define SFC_DESELECT_CYC ((`SFC_T_DESELECT_NS * `SFC_CLK_KHZ + 999999) / 1000000)
`define SFC_WAKE_CYC (`SFC_T_WAKE_US * `SFC_CLK_KHZ / 1000)
`define SFC_MS_CYC(ms) ((ms) * `SFC_CLK_KHZ)
`endif

// File: hw/sfc_pkg.sv
// types shared by both ends of the serial flash command link
package sfc_pkg;
	// flash end operating state
	typedef enum logic [2:0] {
		SFC_DS_STANDBY = 3'b001,
		SFC_DS_BUSY = 3'b010,
		SFC_DS_SLEEP = 3'b100
	} sfc_dev_state_t;
	// host end frame state
	typedef enum logic [4:0] {
		SFC_HS_IDLE = 5'b00001,
		SFC_HS_SELECT = 5'b00010,
		SFC_HS_HIGH = 5'b00100,
		SFC_HS_LOW = 5'b01000,
		SFC_HS_GAP = 5'b10000
	} sfc_host_state_t;
endpackage : sfc_pkg

// File: hw/sfc_link_if.sv
// serial flash link wires between host end and flash end
`timescale 1ns/1ps
interface sfc_link_if;
	logic sclk; // serial clock from host, idle low
	logic cs_n; // chip select, active low
	logic si; // host to flash data
	logic hold_n; // pause, active low
	logic wp_n; // write guard, active low
	logic so; // flash output value
	logic so_oe_n; // flash output enable, low drives
	logic so_line; // resolved wire, pulled high when undriven
	assign so_line = so_oe_n ? 1'b1 : so;
	modport host (output sclk, output cs_n, output si, output hold_n,
		output wp_n, input so_line);
	modport flash (input sclk, input cs_n, input si, input hold_n,
		input wp_n, output so, output so_oe_n);
endinterface : sfc_link_if

// File: hw/sfc_flash.sv
// flash end: command decode, latch, status, sleep and internal cycles
//
// Contract
// - code 06 sets the write latch
// - code 04 clears the write latch
// - code 9f shifts out identification bytes
// - code 20 erases one 4k sector
// - codes 52 and d8 both erase block
// - codes 60 and c7 both erase chip
// - code b9 sleeps within 3 us
// - code ab wakes, optionally reads signature
// - wake reaches standby within 3/1.8 us
// - host keeps clock within read/other limits
// - host clock never below 1 khz
// - host allows status write up to 15 ms
// - host allows page program up to 5 ms; no program command is implemented
// - host observes sector erase completion
// - host allows block erase up to 2 s
// - host allows chip erase up to 3.8 s
// - shipped array reads all ff
// - shipped status register is 00
// - data input ignored while paused
// - write guard matters only when locked
// - power up in standby, latch cleared
`timescale 1ns/1ps
`include "sfc_link_cfg.svh"
module sfc_flash
	import sfc_pkg::*;
#(
	parameter int unsigned STATUS_WRITE_CYC =
		`SFC_MS_CYC(`SFC_T_STATUS_WRITE_TYP_MS),
	parameter int unsigned SMALL_WIPE_CYC =
		`SFC_MS_CYC(`SFC_T_SMALL_WIPE_TYP_MS),
	parameter int unsigned LARGE_WIPE_CYC =
		`SFC_MS_CYC(`SFC_T_LARGE_WIPE_TYP_MS),
	parameter int unsigned WHOLE_WIPE_CYC =
		`SFC_MS_CYC(`SFC_T_WHOLE_WIPE_TYP_MS),
	parameter logic [7:0] MAKER_ID = 8'h5a, // arbitrary value
	parameter logic [7:0] TYPE_ID = 8'h3c, // arbitrary value
	parameter logic [7:0] SIZE_ID = 8'h07, // arbitrary value
	parameter logic [7:0] SIGNATURE_ID = 8'h6e // arbitrary value
) (
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	sfc_link_if.flash link,
	output logic busy_out,
	output logic sleeping_out,
	output logic [7:0] status_out
);
	////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [4:0] pin_meta_reg; // first stage, read only by second
	logic [4:0] pin_sync_reg; // {sclk, cs_n, si, hold_n, wp_n}
	logic sclk_prev_reg; // last synced clock level
	logic cs_prev_reg; // last synced select level
	logic sclk_s, cs_n_s, si_s, hold_n_s, wp_n_s;
	assign {sclk_s, cs_n_s, si_s, hold_n_s, wp_n_s} = pin_sync_reg;
	// two flops on every pin from the host
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			// serial clock, data, pause and guard load high; select loads low
			pin_meta_reg <= 5'h17;
			pin_sync_reg <= 5'h17;
			sclk_prev_reg <= 1'b0;
			cs_prev_reg <= 1'b1;
		end else begin
			pin_meta_reg <= {link.sclk, link.cs_n, link.si, link.hold_n,
				link.wp_n};
			pin_sync_reg <= pin_meta_reg;
			sclk_prev_reg <= sclk_s;
			cs_prev_reg <= cs_n_s;
		end
	end
	// edges count only while selected and not paused
	logic active, rise, fall, frame_end;
	assign active = !cs_n_s && hold_n_s;
	assign rise = active && sclk_s && !sclk_prev_reg;
	assign fall = active && !sclk_s && sclk_prev_reg;
	assign frame_end = cs_n_s && !cs_prev_reg;
	////////////////////////////////////////////////////////////////////
	// input shifting
	logic [7:0] in_sr_reg; // bits being received
	logic [7:0] cmd_reg; // first byte of the frame
	logic [7:0] data_reg; // second byte, status write value
	logic [5:0] bit_cnt_reg; // clocks in frame, saturates
	// shift on rising clock; frame counters restart on deselect
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			in_sr_reg <= 8'h00;
			cmd_reg <= 8'h00;
			data_reg <= 8'h00;
			bit_cnt_reg <= 6'h00;
		end else if (cs_n_s) begin
			bit_cnt_reg <= 6'h00;
		end else if (rise) begin
			in_sr_reg <= {in_sr_reg[6:0], si_s};
			if (bit_cnt_reg != 6'h3f)
				bit_cnt_reg <= bit_cnt_reg + 6'h01;
			if (bit_cnt_reg == 6'h07)
				cmd_reg <= {in_sr_reg[6:0], si_s};
			if (bit_cnt_reg == 6'h0f)
				data_reg <= {in_sr_reg[6:0], si_s};
		end
	end
	////////////////////////////////////////////////////////////////////
	// state, status and internal cycle timer
	sfc_dev_state_t state_reg;
	logic [7:0] status_reg; // lock, guard bits, latch, busy
	logic [27:0] timer_reg; // internal cycle count down
	logic latch_ok, cmd_only, addr_done, wr_ok;
	assign latch_ok = status_reg[`SFC_ST_WRITE_ALLOW_BIT];
	assign cmd_only = bit_cnt_reg == `SFC_BITS_CMD;
	assign addr_done = bit_cnt_reg == `SFC_BITS_ADDR_CMD;
	// guard pin only vetoes when the lock bit is set
	assign wr_ok = latch_ok &&
		!(status_reg[`SFC_ST_LOCK_BIT] && !wp_n_s);
	// commands take effect as select rises
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_reg <= SFC_DS_STANDBY;
			status_reg <= `SFC_ST_RESET;
			timer_reg <= 28'h0;
		end else begin
			case (state_reg)
			SFC_DS_STANDBY: begin
				if (frame_end) begin
					case (cmd_reg)
					`SFC_OP_WRITE_LATCH_SET: begin
						if (cmd_only)
							status_reg[`SFC_ST_WRITE_ALLOW_BIT] <= 1'b1;
					end
					`SFC_OP_WRITE_LATCH_CLEAR: begin
						if (cmd_only)
							status_reg[`SFC_ST_WRITE_ALLOW_BIT] <= 1'b0;
					end
					`SFC_OP_SMALL_REGION_WIPE: begin
						if (addr_done && latch_ok) begin
							timer_reg <= 28'(SMALL_WIPE_CYC);
							status_reg[`SFC_ST_BUSY_BIT] <= 1'b1;
							state_reg <= SFC_DS_BUSY;
						end
					end
					`SFC_OP_LARGE_REGION_WIPE_A,
					`SFC_OP_LARGE_REGION_WIPE_B: begin
						if (addr_done && latch_ok) begin
							timer_reg <= 28'(LARGE_WIPE_CYC);
							status_reg[`SFC_ST_BUSY_BIT] <= 1'b1;
							state_reg <= SFC_DS_BUSY;
						end
					end
					`SFC_OP_WHOLE_WIPE_A, `SFC_OP_WHOLE_WIPE_B: begin
						if (cmd_only && latch_ok) begin
							timer_reg <= 28'(WHOLE_WIPE_CYC);
							status_reg[`SFC_ST_BUSY_BIT] <= 1'b1;
							state_reg <= SFC_DS_BUSY;
						end
					end
					`SFC_OP_STATUS_REGISTER_WRITE: begin
						if (bit_cnt_reg == `SFC_BITS_STATUS_WRITE && wr_ok) begin
							status_reg <= (status_reg & ~`SFC_ST_WRITABLE_MASK) |
								(data_reg & `SFC_ST_WRITABLE_MASK);
							status_reg[`SFC_ST_BUSY_BIT] <= 1'b1;
							timer_reg <= 28'(STATUS_WRITE_CYC);
							state_reg <= SFC_DS_BUSY;
						end
					end
					`SFC_OP_DEEP_SLEEP_ENTRY: begin
						// one cycle after select rises, well inside 3 us
						if (cmd_only)
							state_reg <= SFC_DS_SLEEP;
					end
					default: begin
						state_reg <= SFC_DS_STANDBY;
					end
					endcase
				end
			end
			SFC_DS_BUSY: begin
				// only status reads are served while an internal cycle runs
				if (timer_reg <= 28'h1) begin
					status_reg[`SFC_ST_BUSY_BIT] <= 1'b0;
					status_reg[`SFC_ST_WRITE_ALLOW_BIT] <= 1'b0;
					state_reg <= SFC_DS_STANDBY;
				end else begin
					timer_reg <= timer_reg - 28'h1;
				end
			end
			SFC_DS_SLEEP: begin
				// wake is immediate, inside both 3 us and 1.8 us bounds
				if (frame_end && cmd_reg == `SFC_OP_WAKE_AND_SIGNATURE_READ &&
					bit_cnt_reg >= `SFC_BITS_CMD)
					state_reg <= SFC_DS_STANDBY;
			end
			default: begin
				state_reg <= SFC_DS_STANDBY;
			end
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////
	// output shifting
	// byte offered at a byte boundary; bit 8 says whether to drive
	function automatic logic [8:0] out_byte(input logic [7:0] cmd,
		input logic [5:0] cnt, input sfc_dev_state_t st,
		input logic [7:0] stat);
		logic [8:0] r;
		r = 9'h000;
		if (cmd == `SFC_OP_STATUS_READ && st != SFC_DS_SLEEP)
			r = {1'b1, stat};
		else if (st == SFC_DS_STANDBY) begin
			case (cmd)
			`SFC_OP_STANDARD_IDENT_READ: begin
				case (cnt)
				6'd8: r = {1'b1, MAKER_ID};
				6'd16: r = {1'b1, TYPE_ID};
				6'd24: r = {1'b1, SIZE_ID};
				default: r = 9'h000;
				endcase
			end
			`SFC_OP_WAKE_AND_SIGNATURE_READ: begin
				if (cnt >= `SFC_BITS_ADDR_CMD)
					r = {1'b1, SIGNATURE_ID};
			end
			`SFC_OP_ARRAY_READ: begin
				// no program path exists, so the array stays erased
				if (cnt >= `SFC_BITS_ADDR_CMD)
					r = {1'b1, `SFC_ERASED_BYTE};
			end
			default: r = 9'h000;
			endcase
		end else if (st == SFC_DS_SLEEP &&
			cmd == `SFC_OP_WAKE_AND_SIGNATURE_READ &&
			cnt >= `SFC_BITS_ADDR_CMD)
			r = {1'b1, SIGNATURE_ID};
		return r;
	endfunction : out_byte
	logic [6:0] out_sr_reg; // remaining bits of the byte on the pin
	logic drive_reg; // flash owns the output line
	logic so_reg;
	logic [8:0] next_byte;
	assign next_byte = out_byte(cmd_reg, bit_cnt_reg, state_reg,
		status_reg);
	// change output on falling clock; release line on deselect
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			out_sr_reg <= 7'h00;
			drive_reg <= 1'b0;
			so_reg <= 1'b0;
		end else if (cs_n_s) begin
			drive_reg <= 1'b0;
		end else if (fall && bit_cnt_reg[2:0] == 3'h0 &&
			bit_cnt_reg >= `SFC_BITS_CMD) begin
			drive_reg <= next_byte[8];
			so_reg <= next_byte[7];
			out_sr_reg <= next_byte[6:0];
		end else if (fall) begin
			so_reg <= out_sr_reg[6];
			out_sr_reg <= {out_sr_reg[5:0], 1'b0};
		end
	end
	// line floats while paused, comes back when pause lifts
	logic so_oe_n_reg;
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in)
			so_oe_n_reg <= 1'b1;
		else
			so_oe_n_reg <= !(drive_reg && hold_n_s && !cs_n_s);
	end
	assign link.so = so_reg;
	assign link.so_oe_n = so_oe_n_reg;
	////////////////////////////////////////////////////////////////////
	// user side observation, all from flops
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			busy_out <= 1'b0;
			sleeping_out <= 1'b0;
			status_out <= `SFC_ST_RESET;
		end else begin
			busy_out <= state_reg == SFC_DS_BUSY;
			sleeping_out <= state_reg == SFC_DS_SLEEP;
			status_out <= status_reg;
		end
	end
endmodule : sfc_flash

// File: hw/sfc_host.sv
// host end: frames commands, makes the serial clock, polls busy
`timescale 1ns/1ps
`include "sfc_link_cfg.svh"
module sfc_host
	import sfc_pkg::*;
#(
	parameter int unsigned HALF_CYC = 4, // half serial clock in cycles
	parameter int unsigned STATUS_WRITE_MAX_CYC =
		`SFC_MS_CYC(`SFC_T_STATUS_WRITE_MAX_MS),
	parameter int unsigned LARGE_WIPE_MAX_CYC =
		`SFC_MS_CYC(`SFC_T_LARGE_WIPE_MAX_MS),
	parameter int unsigned WHOLE_WIPE_MAX_CYC =
		`SFC_MS_CYC(`SFC_T_WHOLE_WIPE_MAX_MS)
) (
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	sfc_link_if.host link,
	input wire logic req_valid_in,
	input wire logic [7:0] req_code_in,
	input wire logic [23:0] req_addr_in,
	input wire logic [7:0] req_data_in,
	input wire logic [1:0] req_rd_bytes_in,
	input wire logic pause_in,
	input wire logic guard_in,
	output logic ready_out,
	output logic done_out,
	output logic timeout_out,
	output logic [23:0] rdata_out,
	output logic sclk_out_unused
);
	// serial clock is clk/(2*HALF_CYC): 5 mhz, under the read limit
	localparam int unsigned SCLK_KHZ = `SFC_CLK_KHZ / (2 * HALF_CYC);
	localparam bit SCLK_OK = SCLK_KHZ <= `SFC_READ_MAX_KHZ &&
		SCLK_KHZ >= `SFC_MIN_KHZ;
	localparam logic [7:0] HALF_M1 = 8'(HALF_CYC - 1);
	localparam logic [7:0] DESEL_CYC = 8'(`SFC_DESELECT_CYC);
	localparam logic [7:0] WAKE_CYC = 8'(`SFC_WAKE_CYC);
	////////////////////////////////////////////////////////////////////
	// returned data synchroniser
	logic so_meta_reg, so_sync_reg;
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			so_meta_reg <= 1'b1;
			so_sync_reg <= 1'b1;
		end else begin
			so_meta_reg <= link.so_line;
			so_sync_reg <= so_meta_reg;
		end
	end
	////////////////////////////////////////////////////////////////////
	// frame sequencer
	sfc_host_state_t state_reg;
	logic [31:0] tx_reg; // bits still to send, msb first
	logic [5:0] left_reg; // clocks remaining in frame
	logic [7:0] wait_reg; // phase timer
	logic [7:0] code_reg; // command of the frame in flight
	logic polling_reg; // waiting on flash busy bit
	logic [27:0] limit_reg; // allowed cycles, zero means unbounded
	logic [27:0] elapsed_reg; // cycles since long op issued
	logic sclk_reg, cs_n_reg;
	logic long_op;
	assign long_op = req_code_in == `SFC_OP_SMALL_REGION_WIPE ||
		req_code_in == `SFC_OP_LARGE_REGION_WIPE_A ||
		req_code_in == `SFC_OP_LARGE_REGION_WIPE_B ||
		req_code_in == `SFC_OP_WHOLE_WIPE_A ||
		req_code_in == `SFC_OP_WHOLE_WIPE_B ||
		req_code_in == `SFC_OP_STATUS_REGISTER_WRITE;
	// clocks to send for a request, address frames carry 24 more
	function automatic logic [5:0] tx_len(input logic [7:0] c,
		input logic [1:0] rd);
		case (c)
		`SFC_OP_SMALL_REGION_WIPE, `SFC_OP_LARGE_REGION_WIPE_A,
		`SFC_OP_LARGE_REGION_WIPE_B, `SFC_OP_ARRAY_READ:
			tx_len = `SFC_BITS_ADDR_CMD;
		`SFC_OP_STATUS_REGISTER_WRITE: tx_len = `SFC_BITS_STATUS_WRITE;
		`SFC_OP_WAKE_AND_SIGNATURE_READ:
			tx_len = rd != 2'h0 ? `SFC_BITS_ADDR_CMD : `SFC_BITS_CMD;
		default: tx_len = `SFC_BITS_CMD;
		endcase
		tx_len = tx_len + {1'b0, rd, 3'h0};
	endfunction : tx_len
	// per-operation maximum; sector wipe has none, so only polling ends it
	function automatic logic [27:0] op_limit(input logic [7:0] c);
		case (c)
		`SFC_OP_STATUS_REGISTER_WRITE: op_limit = 28'(STATUS_WRITE_MAX_CYC);
		`SFC_OP_LARGE_REGION_WIPE_A, `SFC_OP_LARGE_REGION_WIPE_B:
			op_limit = 28'(LARGE_WIPE_MAX_CYC);
		`SFC_OP_WHOLE_WIPE_A, `SFC_OP_WHOLE_WIPE_B:
			op_limit = 28'(WHOLE_WIPE_MAX_CYC);
		default: op_limit = 28'h0;
		endcase
	endfunction : op_limit
	// one process walks select, clock phases and deselect gap
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_reg <= SFC_HS_IDLE;
			tx_reg <= 32'h0;
			left_reg <= 6'h0;
			wait_reg <= 8'h0;
			code_reg <= 8'h0;
			polling_reg <= 1'b0;
			limit_reg <= 28'h0;
			elapsed_reg <= 28'h0;
			sclk_reg <= 1'b0;
			cs_n_reg <= 1'b1;
			rdata_out <= 24'h0;
			done_out <= 1'b0;
			timeout_out <= 1'b0;
			ready_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			if (polling_reg && elapsed_reg != 28'hfffffff)
				elapsed_reg <= elapsed_reg + 28'h1;
			case (state_reg)
			SFC_HS_IDLE: begin
				ready_out <= SCLK_OK;
				if (req_valid_in && ready_out) begin
					ready_out <= 1'b0;
					timeout_out <= 1'b0;
					code_reg <= req_code_in;
					tx_reg <= {req_code_in,
						req_code_in == `SFC_OP_STATUS_REGISTER_WRITE ?
						{req_data_in, 16'h0} : req_addr_in};
					left_reg <= tx_len(req_code_in, req_rd_bytes_in);
					polling_reg <= long_op;
					limit_reg <= op_limit(req_code_in);
					elapsed_reg <= 28'h0;
					rdata_out <= 24'h0;
					cs_n_reg <= 1'b0;
					wait_reg <= HALF_M1;
					state_reg <= SFC_HS_SELECT;
				end
			end
			SFC_HS_SELECT, SFC_HS_LOW: begin
				if (wait_reg != 8'h0) begin
					wait_reg <= wait_reg - 8'h1;
				end else if (left_reg == 6'h0) begin
					cs_n_reg <= 1'b1;
					wait_reg <= (code_reg == `SFC_OP_DEEP_SLEEP_ENTRY ||
						code_reg == `SFC_OP_WAKE_AND_SIGNATURE_READ) ?
						WAKE_CYC : DESEL_CYC;
					state_reg <= SFC_HS_GAP;
				end else begin
					sclk_reg <= 1'b1;
					wait_reg <= HALF_M1;
					state_reg <= SFC_HS_HIGH;
				end
			end
			SFC_HS_HIGH: begin
				if (wait_reg != 8'h0) begin
					wait_reg <= wait_reg - 8'h1;
				end else begin
					// sample late in the high phase to cover sync delay
					rdata_out <= {rdata_out[22:0], so_sync_reg};
					sclk_reg <= 1'b0;
					tx_reg <= {tx_reg[30:0], 1'b0};
					left_reg <= left_reg - 6'h1;
					wait_reg <= HALF_M1;
					state_reg <= SFC_HS_LOW;
				end
			end
			SFC_HS_GAP: begin
				if (wait_reg != 8'h0) begin
					wait_reg <= wait_reg - 8'h1;
				end else if (polling_reg &&
					(code_reg != `SFC_OP_STATUS_READ ||
					rdata_out[`SFC_ST_BUSY_BIT])) begin
					if (limit_reg != 28'h0 && elapsed_reg >= limit_reg) begin
						timeout_out <= 1'b1;
						polling_reg <= 1'b0;
						done_out <= 1'b1;
						state_reg <= SFC_HS_IDLE;
					end else begin
						// long op just sent or busy still set: ask for the status byte
						code_reg <= `SFC_OP_STATUS_READ;
						tx_reg <= {`SFC_OP_STATUS_READ, 24'h0};
						left_reg <= `SFC_BITS_STATUS_WRITE;
						rdata_out <= 24'h0;
						cs_n_reg <= 1'b0;
						wait_reg <= HALF_M1;
						state_reg <= SFC_HS_SELECT;
					end
				end else begin
					polling_reg <= 1'b0;
					done_out <= 1'b1;
					state_reg <= SFC_HS_IDLE;
				end
			end
			default: begin
				state_reg <= SFC_HS_IDLE;
			end
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////
	// pin drivers, all from flops
	logic hold_n_reg, wp_n_reg;
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			hold_n_reg <= 1'b1;
			wp_n_reg <= 1'b1;
			sclk_out_unused <= 1'b0;
		end else begin
			hold_n_reg <= !pause_in;
			wp_n_reg <= !guard_in;
			sclk_out_unused <= sclk_reg;
		end
	end
	assign link.sclk = sclk_reg;
	assign link.cs_n = cs_n_reg;
	assign link.si = tx_reg[31];
	assign link.hold_n = hold_n_reg;
	assign link.wp_n = wp_n_reg;
endmodule : sfc_host

// File: sim/sfc_link_props.sv
// checker for the serial flash link and the flash end state
`timescale 1ns/1ps
module sfc_link_props (
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	input wire logic sclk,
	input wire logic sclk_copy,
	input wire logic cs_n,
	input wire logic hold_n,
	input wire logic so_oe_n,
	input wire logic busy_out,
	input wire logic sleeping_out,
	input wire logic [7:0] status_out
);
	localparam int SLEEP_MAX = 120; // 3 us of 25 ns cycles
	logic [7:0] desel_reg; // cycles since select was released
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!resetn_in);
	////////////////////////////////////////////////////////////////////////
	// saturating count so a late mode change shows as a large value
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			desel_reg <= 8'hff;
		end else if (!cs_n) begin
			desel_reg <= 8'h00;
		end else if (desel_reg != 8'hff) begin
			desel_reg <= desel_reg + 8'h01;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// mode changes act only after the frame has closed
	sequence desel_s;
		cs_n && $past(cs_n);
	endsequence
	// output release lags the pin by sync plus one register stage
	sequence desel_held_s;
		cs_n && $past(cs_n) && $past(cs_n, 2) && $past(cs_n, 3);
	endsequence
	sequence pause_held_s;
		!hold_n && !$past(hold_n) && !$past(hold_n, 2) &&
			!$past(hold_n, 3);
	endsequence
	idle_clk_low_a: assert property (cs_n |-> !sclk)
		else $error("serial clock not low while deselected");
	desel_out_off_a: assert property (desel_held_s |-> so_oe_n)
		else $error("flash drives output while deselected");
	pause_out_off_a: assert property (pause_held_s |-> so_oe_n)
		else $error("flash drives output while paused");
	sclk_copy_a: assert property (sclk_copy == $past(sclk))
		else $error("serial clock monitor copy out of step");
	ship_state_a: assert property ($rose(resetn_in) |->
		status_out == 8'h00 && !busy_out && !sleeping_out)
		else $error("state after reset not standby with clear status");
	sleep_entry_a: assert property ($rose(sleeping_out) |->
		desel_s ##0 desel_reg <= SLEEP_MAX)
		else $error("deep sleep entry late or inside a frame");
	wake_exit_a: assert property ($fell(sleeping_out) |->
		desel_s ##0 desel_reg <= SLEEP_MAX)
		else $error("wake late or inside a frame");
	wipe_start_a: assert property ($rose(busy_out) |-> status_out[1])
		else $error("internal cycle began without write latch");
	wipe_end_a: assert property ($fell(busy_out) |-> !status_out[1])
		else $error("write latch not cleared at cycle end");
	busy_bit_a: assert property (status_out[0] == busy_out)
		else $error("busy status bit differs from busy output");
	sleep_busy_a: assert property (sleeping_out |-> !busy_out)
		else $error("busy while in deep sleep");
	fixed_bits_a: assert property (status_out[6:4] == 3'b000)
		else $error("unwritable status bits changed");
endmodule : sfc_link_props

// File: sim/testbench.sv
// testbench joining host end and flash end over the link interface
`timescale 1ns/1ps
module testbench;
	import sfc_pkg::*;
	localparam int CYC = 300; // shortened internal cycle length
	localparam logic [7:0] MK = 8'h5a; // arbitrary value
	localparam logic [7:0] TY = 8'h3c; // arbitrary value
	localparam logic [7:0] SZ = 8'h07; // arbitrary value
	localparam logic [7:0] SG = 8'h6e; // arbitrary value
	logic ref_clk_in = 1'b0, resetn_in = 1'b0;
	logic req_valid = 1'b0, pause = 1'b0, guard = 1'b0;
	logic [7:0] code = 8'h00, data = 8'h00;
	logic [23:0] addr = 24'h000000;
	logic [1:0] rd = 2'd0;
	logic ready, done, tmo, busy, slp, seen_busy;
	logic [23:0] rdata;
	logic sclk_cp; // host monitor copy of the serial clock
	logic [7:0] status;
	int errors = 0, n_tests = 0;
	sfc_link_if link_if();
	////////////////////////////////////////////////////////////////////////
	sfc_flash #(.STATUS_WRITE_CYC(CYC), .SMALL_WIPE_CYC(CYC),
		.LARGE_WIPE_CYC(CYC), .WHOLE_WIPE_CYC(CYC), .MAKER_ID(MK),
		.TYPE_ID(TY), .SIZE_ID(SZ), .SIGNATURE_ID(SG)) sfc_flash_inst (
		.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .link(link_if),
		.busy_out(busy), .sleeping_out(slp), .status_out(status));
	// host maxima above the flash cycle so no timeout is expected
	sfc_host #(.HALF_CYC(4), .STATUS_WRITE_MAX_CYC(2000),
		.LARGE_WIPE_MAX_CYC(2000), .WHOLE_WIPE_MAX_CYC(2000))
		sfc_host_inst (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
		.link(link_if), .req_valid_in(req_valid), .req_code_in(code),
		.req_addr_in(addr), .req_data_in(data), .req_rd_bytes_in(rd),
		.pause_in(pause), .guard_in(guard), .ready_out(ready),
		.done_out(done), .timeout_out(tmo), .rdata_out(rdata),
		.sclk_out_unused(sclk_cp));
	sfc_link_props sfc_link_props_inst (.ref_clk_in(ref_clk_in),
		.resetn_in(resetn_in), .sclk(link_if.sclk), .sclk_copy(sclk_cp),
		.cs_n(link_if.cs_n),
		.hold_n(link_if.hold_n), .so_oe_n(link_if.so_oe_n),
		.busy_out(busy), .sleeping_out(slp), .status_out(status));
	////////////////////////////////////////////////////////////////////////
	// clock and a flag that records any internal cycle
	initial begin
		forever #12.5 ref_clk_in = ~ref_clk_in;
	end
	always @(posedge ref_clk_in) begin
		if (busy === 1'b1) seen_busy <= 1'b1;
	end
	task automatic chk(input string nm, input logic [23:0] got,
		input logic [23:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : test_done
	// one request at the user port, waits for its done pulse
	task automatic cmd(input logic [7:0] c, input logic [23:0] a,
		input logic [7:0] d, input logic [1:0] r);
		int i;
		for (i = 0; i < 100 && ready !== 1'b1; i++) @(negedge ref_clk_in);
		code = c;
		addr = a;
		data = d;
		rd = r;
		req_valid = 1'b1;
		@(negedge ref_clk_in);
		req_valid = 1'b0;
		for (i = 0; i < 20000 && done !== 1'b1; i++) @(negedge ref_clk_in);
		chk("done", {23'd0, done}, 24'd1);
	endtask : cmd
	// latch, then a wipe; latch cleared and no timeout afterwards
	task automatic wipe(input logic [7:0] c);
		cmd(8'h06, 24'h0, 8'h0, 2'd0);
		seen_busy = 1'b0;
		cmd(c, 24'h001000, 8'h0, 2'd0);
		chk("wipe ran", {23'd0, seen_busy}, 24'd1);
		chk("latch after", {23'd0, status[1]}, 24'd0);
		chk("timeout", {23'd0, tmo}, 24'd0);
		$display("test wipe %h done", c);
	endtask : wipe
	////////////////////////////////////////////////////////////////////////
	initial begin
		#2000000;
		errors++;
		test_done();
	end
	initial begin
		// seven rising edges pass under reset
		repeat (7) @(negedge ref_clk_in);
		resetn_in = 1'b1;
		repeat (2) @(negedge ref_clk_in);
		chk("status", {16'd0, status}, 24'h0);
		chk("sleep", {23'd0, slp}, 24'd0);
		cmd(8'h05, 24'h0, 8'h0, 2'd1);
		// only the last byte read is defined; earlier bits are the idle line
		chk("status rd", {16'd0, rdata[7:0]}, 24'h0);
		cmd(8'h03, 24'h000100, 8'h0, 2'd3);
		chk("array", rdata, 24'hffffff);
		cmd(8'h9f, 24'h0, 8'h0, 2'd3);
		chk("ident", rdata, {MK, TY, SZ});
		$display("test reads done");
		cmd(8'h06, 24'h0, 8'h0, 2'd0);
		chk("latch set", {23'd0, status[1]}, 24'd1);
		cmd(8'h04, 24'h0, 8'h0, 2'd0);
		chk("latch clr", {23'd0, status[1]}, 24'd0);
		seen_busy = 1'b0;
		cmd(8'h20, 24'h001000, 8'h0, 2'd0);
		chk("no latch", {23'd0, seen_busy}, 24'd0);
		$display("test latch done");
		wipe(8'h20);
		wipe(8'h52);
		wipe(8'hd8);
		wipe(8'h60);
		wipe(8'hc7);
		cmd(8'hb9, 24'h0, 8'h0, 2'd0);
		chk("asleep", {23'd0, slp}, 24'd1);
		cmd(8'h06, 24'h0, 8'h0, 2'd0);
		chk("sleep latch", {23'd0, status[1]}, 24'd0);
		cmd(8'hab, 24'h0, 8'h0, 2'd0);
		chk("awake", {23'd0, slp}, 24'd0);
		cmd(8'hb9, 24'h0, 8'h0, 2'd0);
		cmd(8'hab, 24'h0, 8'h0, 2'd1);
		chk("signature", {16'd0, rdata[7:0]}, {16'd0, SG});
		chk("awake sig", {23'd0, slp}, 24'd0);
		$display("test sleep done");
		cmd(8'h06, 24'h0, 8'h0, 2'd0);
		cmd(8'h01, 24'h0, 8'h8c, 2'd0);
		chk("sw lock", {16'd0, status}, 24'h8c);
		guard = 1'b1;
		cmd(8'h06, 24'h0, 8'h0, 2'd0);
		cmd(8'h01, 24'h0, 8'h00, 2'd0);
		chk("guarded", {16'd0, status & 8'h8c}, 24'h8c);
		guard = 1'b0;
		cmd(8'h06, 24'h0, 8'h0, 2'd0);
		cmd(8'h01, 24'h0, 8'h00, 2'd0);
		chk("unguard", {16'd0, status}, 24'h0);
		pause = 1'b1;
		repeat (4) @(negedge ref_clk_in);
		chk("pause", {23'd0, link_if.hold_n}, 24'd0);
		// a whole frame sent while paused must leave the latch alone
		cmd(8'h06, 24'h0, 8'h0, 2'd0);
		chk("paused latch", {23'd0, status[1]}, 24'd0);
		pause = 1'b0;
		repeat (4) @(negedge ref_clk_in);
		$display("test guard done");
		test_done();
	end
endmodule : testbench
